// [core/ssf_pkg.sv]
/*
  shared constants and carrier types of the spi status flag block.
  assumes an apb slave port with 32-bit data and a byte address whose
  register index sits in bits [9:2].
*/
package ssf_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;                 // apb byte address width
  localparam int DATA_W = 32;                 // apb data width
  localparam int WORD_W = 8;                  // serial character width

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0]        IDX_CTRL    = 8'h00;   // control word
  localparam logic [7:0]        IDX_STATUS  = 8'h1A;   // status flags
  localparam logic [7:0]        IDX_DATA    = 8'h28;   // received word
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DATA   = {2'h0, IDX_DATA, 2'h0};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STAT_LEN_BIT   = 11;         // length_mismatch_flag
  localparam int STAT_OVF_BIT   = 2;          // overrun_flag
  localparam int CTRL_RXEN_BIT  = 0;          // receiver enable
  localparam int CTRL_SLAVE_BIT = 1;          // slave mode
  localparam int CTRL_LENON_BIT = 2;          // length_counter_on
  localparam int CTRL_FCS_LSB   = 8;          // frame_count_setting [15:8]

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0]       STATUS_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [1:0]        CHK_DELAY  = 2'h3;   // pclk cycles after frame end
  localparam logic [2:0]        BIT_LAST   = 3'h7;   // last bit of a character

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              rx_en;                 // receiver enable
    logic              slave_mode;            // device is spi slave
    logic              length_counter_on;     // length check enabled
    logic [7:0]        frame_count_setting;   // words per transaction
  } ssf_ctrl_t;

  typedef struct packed {
    logic              tog;                   // flips once per character
    logic [WORD_W-1:0] word;                  // last full character
  } ssf_link_t;

endpackage : ssf_pkg

// [core/ssf_link_rx.sv]
/*
  link-side receiver: shifts mosi on the link clock and hands each full
  character over with a toggle. assumes the link clock only runs while
  ss_n is low and that a character is stable for eight link cycles.
*/
module ssf_link_rx (
  input  wire logic              link_clk,    // spi clock from the master
  input  wire logic              presetn,     // global reset, active low
  input  wire logic              ss_n,        // slave select, active low
  input  wire logic              mosi,        // serial data in
  output ssf_pkg::ssf_link_t     link_out     // toggle and held character
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cnt;                          // bit position in character
    logic [6:0] shift;                        // partial character
  } ssf_lnk_bits_t;

  ssf_pkg::ssf_link_t hold_r, hold_nxt;       // survives between frames
  ssf_lnk_bits_t      bits_r, bits_nxt;       // dies with the frame
  logic               frame_rst_n;            // reset while deselected

  // partial bits must not leak into the next frame; the link clock is
  // gone by then, so ss_n itself clears them
  assign frame_rst_n = presetn & ~ss_n;

  // next-state logic
  always_comb begin
    hold_nxt = hold_r;
    bits_nxt = bits_r;
    bits_nxt.shift = {bits_r.shift[5:0], mosi};
    bits_nxt.cnt   = bits_r.cnt + 3'h1;
    if (bits_r.cnt == ssf_pkg::BIT_LAST) begin
      // full character: publish word before the toggle is seen
      hold_nxt.word = {bits_r.shift, mosi};
      hold_nxt.tog  = ~hold_r.tog;
    end
  end

  // held word and toggle, reset only globally so no false event
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= '0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // bit counter, cleared at every frame end
  always_ff @(posedge link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bits_r <= '0;
    end else begin
      bits_r <= bits_nxt;
    end
  end

  assign link_out = hold_r;

endmodule : ssf_link_rx

// [core/ssf_status.sv]
/*
  status flag unit of an spi peripheral: length mismatch and overrun
  flags, a one-deep receive holding register and an apb slave.
  assumes an apb master on pclk, an spi master driving link_clk, ss_n
  and mosi, and a block-wide clock enable on the pclk side.
*/
// Notes on behaviour
// - slave with counter on flags length mismatch
// - write one clears flag, zero keeps
// - overrun flag set on receive overflow
// - receiver disable also clears overrun flag
// - status read shows the overrun flag as it stood in the setup cycle
// - overrun character reads as zero
// - status reads zero after reset
module ssf_status (
  input  wire logic                       pclk,       // bus clock
  input  wire logic                       presetn,    // async reset, active low
  input  wire logic                       ce,         // clock enable, freezes state
  input  wire logic                       psel,       // apb select
  input  wire logic                       penable,    // apb access phase
  input  wire logic                       pwrite,     // apb direction
  input  wire logic [ssf_pkg::ADDR_W-1:0] paddr,      // apb byte address
  input  wire logic [ssf_pkg::DATA_W-1:0] pwdata,     // apb write data
  output logic      [ssf_pkg::DATA_W-1:0] prdata,     // apb read data
  output logic                            pready,     // apb ready
  output logic                            pslverr,    // apb error
  input  wire logic                       link_clk,   // spi clock
  input  wire logic                       ss_n,       // slave select pin
  input  wire logic                       mosi        // serial data pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssf_pkg::ssf_ctrl_t          ctrl;        // software control
    logic                        len_flag;    // length_mismatch_flag
    logic                        ovf_flag;    // overrun_flag
    logic [ssf_pkg::WORD_W-1:0]  rx_word;     // head of receive buffer
    logic                        rx_full;     // rx_word valid
    logic                        rx_tag;      // head character overran
    logic                        ss_s1;       // ss_n sync stage one
    logic                        ss_s2;       // ss_n sync stage two
    logic                        ss_prev;     // for edge detect
    logic                        tog_s1;      // toggle sync stage one
    logic                        tog_s2;      // toggle sync stage two
    logic                        tog_prev;    // for edge detect
    logic [7:0]                  frame_pos;   // words modulo setting
    logic [1:0]                  chk_dly;     // countdown to length check
    logic [ssf_pkg::DATA_W-1:0]  prdata;      // registered read data
    logic                        pready;      // registered ready
    logic                        pslverr;     // registered error
  } ssf_state_t;

  ssf_state_t         st_r, st_nxt;           // registered and next state
  ssf_pkg::ssf_link_t link_w;                 // from the link domain
  logic               setup_w;                // apb setup cycle
  logic               access_w;               // apb completing edge
  logic               word_evt;               // new character arrived
  logic               frame_end;              // ss_n rose
  logic               frame_start;            // ss_n fell
  logic               pop_w;                  // software reads data
  logic               wr_status;              // software writes status
  logic [15:0]        status_w;               // status register image

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sticky flag update: hardware set beats a write-one clear
  function automatic logic w1c_update(input logic cur, input logic set,
                                      input logic clr);
    w1c_update = (cur & ~clr) | set;
  endfunction : w1c_update

  // position in the transaction, wrapping at the configured length
  function automatic logic [7:0] next_pos(input logic [7:0] pos,
                                          input logic [7:0] len);
    if (pos + 8'h01 >= len) begin
      next_pos = 8'h00;
    end else begin
      next_pos = pos + 8'h01;
    end
  endfunction : next_pos

  // ----------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------
  ssf_link_rx u_link (
    .link_clk (link_clk),
    .presetn  (presetn),
    .ss_n     (ss_n),
    .mosi     (mosi),
    .link_out (link_w)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign setup_w     = psel & ~penable;
  assign access_w    = psel & penable & st_r.pready;
  assign word_evt    = st_r.tog_s2 ^ st_r.tog_prev;
  assign frame_end   = st_r.ss_s2 & ~st_r.ss_prev;
  assign frame_start = ~st_r.ss_s2 & st_r.ss_prev;
  assign pop_w       = access_w & ~pwrite & (paddr == ssf_pkg::ADDR_DATA);
  assign wr_status   = access_w & pwrite & (paddr == ssf_pkg::ADDR_STATUS);

  // status image, reserved bits read as zero
  always_comb begin
    status_w                        = ssf_pkg::STATUS_RST;
    status_w[ssf_pkg::STAT_LEN_BIT] = st_r.len_flag;
    status_w[ssf_pkg::STAT_OVF_BIT] = st_r.ovf_flag;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic len_set;                            // mismatch found this cycle
    logic ovf_set;                            // overflow found this cycle
    len_set = 1'b0;
    ovf_set = 1'b0;
    st_nxt  = st_r;

    // two-flop synchronisers; stage one feeds stage two only
    st_nxt.ss_s1    = ss_n;
    st_nxt.ss_s2    = st_r.ss_s1;
    st_nxt.ss_prev  = st_r.ss_s2;
    st_nxt.tog_s1   = link_w.tog;
    st_nxt.tog_s2   = st_r.tog_s1;
    st_nxt.tog_prev = st_r.tog_s2;

    // software pops the head character
    if (pop_w) begin
      st_nxt.rx_full = 1'b0;
      st_nxt.rx_tag  = 1'b0;
    end

    // receive: word is stable long before its toggle arrives here
    if (word_evt && st_r.ctrl.rx_en) begin
      st_nxt.frame_pos = next_pos(st_r.frame_pos,
                                  st_r.ctrl.frame_count_setting);
      if (st_r.rx_full && !pop_w) begin
        // overflow: the lost slot is marked and zeroed
        ovf_set        = 1'b1;
        st_nxt.rx_word = '0;
        st_nxt.rx_tag  = 1'b1;
      end else begin
        st_nxt.rx_word = link_w.word;
        st_nxt.rx_tag  = 1'b0;
      end
      st_nxt.rx_full = 1'b1;
    end

    // transaction boundaries
    if (frame_start) begin
      st_nxt.frame_pos = 8'h00;
      st_nxt.chk_dly   = 2'h0;
    end
    if (frame_end) begin
      // wait so the last character's toggle is counted first
      st_nxt.chk_dly = ssf_pkg::CHK_DELAY;
    end else if (st_r.chk_dly != 2'h0) begin
      st_nxt.chk_dly = st_r.chk_dly - 2'h1;
      if (st_r.chk_dly == 2'h1) begin
        // a setting of zero disables the check
        len_set = st_r.ctrl.slave_mode & st_r.ctrl.length_counter_on
                & (st_r.ctrl.frame_count_setting != 8'h00)
                & (st_r.frame_pos != 8'h00);
      end
    end

    // flags: set wins over write-one clear
    st_nxt.len_flag = w1c_update(st_r.len_flag, len_set,
                                 wr_status & pwdata[ssf_pkg::STAT_LEN_BIT]);
    st_nxt.ovf_flag = w1c_update(st_r.ovf_flag, ovf_set,
                                 wr_status & pwdata[ssf_pkg::STAT_OVF_BIT]);
    if (!st_r.ctrl.rx_en) begin
      // receiver off: no set can occur, so the clear is safe
      st_nxt.ovf_flag = 1'b0;
      st_nxt.rx_full  = 1'b0;
      st_nxt.rx_tag   = 1'b0;
    end

    // control write
    if (access_w && pwrite && paddr == ssf_pkg::ADDR_CTRL) begin
      st_nxt.ctrl.rx_en               = pwdata[ssf_pkg::CTRL_RXEN_BIT];
      st_nxt.ctrl.slave_mode          = pwdata[ssf_pkg::CTRL_SLAVE_BIT];
      st_nxt.ctrl.length_counter_on   = pwdata[ssf_pkg::CTRL_LENON_BIT];
      st_nxt.ctrl.frame_count_setting = pwdata[ssf_pkg::CTRL_FCS_LSB +: 8];
    end

    // apb answer: ready in the access phase, one wait-free cycle
    st_nxt.pready  = setup_w;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = '0;
    if (setup_w) begin
      if (paddr == ssf_pkg::ADDR_CTRL) begin
        st_nxt.prdata[ssf_pkg::CTRL_RXEN_BIT]     = st_r.ctrl.rx_en;
        st_nxt.prdata[ssf_pkg::CTRL_SLAVE_BIT]    = st_r.ctrl.slave_mode;
        st_nxt.prdata[ssf_pkg::CTRL_LENON_BIT]    = st_r.ctrl.length_counter_on;
        st_nxt.prdata[ssf_pkg::CTRL_FCS_LSB +: 8] = st_r.ctrl.frame_count_setting;
      end else if (paddr == ssf_pkg::ADDR_STATUS) begin
        st_nxt.prdata[15:0] = status_w;
      end else if (paddr == ssf_pkg::ADDR_DATA) begin
        st_nxt.prdata[ssf_pkg::WORD_W-1:0] = st_r.rx_word;
      end else begin
        // unmapped: error with zero data
        st_nxt.pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all pclk-side state in one register; ce low freezes all of it, the link side keeps running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.ctrl     <= ssf_pkg::ssf_ctrl_t'(ssf_pkg::CTRL_RST[10:0]);
      st_r.ss_s1    <= 1'b1;
      st_r.ss_s2    <= 1'b1;
      st_r.ss_prev  <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_status_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (status_w == 16'h0000))
    else $error("status not zero after reset");

  a_len_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && st_r.chk_dly == 2'h1 && !frame_end && st_r.ctrl.slave_mode
      && st_r.ctrl.length_counter_on && st_r.ctrl.frame_count_setting != 8'h00
      && st_r.frame_pos != 8'h00 |=> st_r.len_flag)
    else $error("length mismatch not flagged");

  a_len_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st_r.len_flag) |-> $past(st_r.ctrl.slave_mode)
      && $past(st_r.ctrl.length_counter_on))
    else $error("length flag set as master or counter off");

  a_w1c_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && wr_status && pwdata[ssf_pkg::STAT_LEN_BIT] && st_r.chk_dly == 2'h0
      |=> !st_r.len_flag)
    else $error("write one did not clear length flag");

  a_w0_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && wr_status && !pwdata[ssf_pkg::STAT_OVF_BIT] && st_r.ovf_flag
      && st_r.ctrl.rx_en |=> st_r.ovf_flag)
    else $error("write zero changed overrun flag");

  a_ovf_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && word_evt && st_r.ctrl.rx_en && st_r.rx_full && !pop_w
      |=> st_r.ovf_flag && st_r.rx_tag)
    else $error("overflow not flagged");

  a_rxoff_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !st_r.ctrl.rx_en |=> !st_r.ovf_flag)
    else $error("overrun flag survives receiver disable");

  a_tag_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.rx_full && st_r.rx_tag |-> st_r.rx_word == '0)
    else $error("overrun character not zero");

  a_status_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && setup_w && paddr == ssf_pkg::ADDR_STATUS
      |=> pready && prdata[ssf_pkg::STAT_OVF_BIT] == $past(st_r.ovf_flag))
    else $error("status read does not show overrun state");

  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && pready && penable |=> !pready)
    else $error("ready held beyond access phase");

endmodule : ssf_status

// [verification/ssf_spi_master.sv]
/*
  spi master model driving the serial pins of the status flag block.
  assumes the block samples mosi on the rising link clock, msb first,
  and that frames are spaced by the caller.
*/
module ssf_spi_master (
  output logic link_clk,  // spi clock, idle low, 160 ns period
  output logic ss_n,      // slave select, active low
  output logic mosi       // serial data out, msb first
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    link_clk = 1'b0;
    ss_n     = 1'b1;
    mosi     = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame of n whole characters taken from the low bytes of w
  // ----------------------------------------------------------------
  task automatic send(input int n, input logic [15:0] w);
    #37;                              // odd offset keeps phase unrelated to pclk
    ss_n = 1'b0;
    #80;
    for (int i = 0; i < 8 * n; i++) begin
      mosi = w[8 * n - 1 - i];        // data set while clock is low
      #80 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    #80;
    ss_n = 1'b1;
    mosi = ~mosi;                     // released line must not show stale data
  endtask : send
endmodule : ssf_spi_master

// [verification/tb.sv]
/*
  self-checking bench of the spi status flag block.
  assumes the apb answer, status layout and control layout of the package;
  the serial side is driven by the spi master model.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                       pclk, presetn, ce;   // clock, reset, enable
  logic                       psel, penable, pwrite; // apb control
  logic [ssf_pkg::ADDR_W-1:0] paddr;                // apb address
  logic [ssf_pkg::DATA_W-1:0] pwdata, prdata;       // apb data
  logic                       pready, pslverr;      // apb answer
  logic                       link_clk, ss_n, mosi; // serial pins
  logic [31:0]                rd, seed;             // last read, lfsr state
  logic                       er;                   // last error answer
  int                         fails, num_checks, cyc;

  always #4 pclk = ~pclk;  // 125 MHz

  ssf_status u_ssf_status (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .ss_n(ss_n), .mosi(mosi));
  ssf_spi_master u_ssf_spi_master (.link_clk(link_clk), .ss_n(ss_n), .mosi(mosi));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // expected length flag: whole characters not a multiple of the setting
  function automatic logic exp_len(input logic sl, input logic lo, input logic [7:0] set,
                                   input int n);
    return sl && lo && (set != 8'h00) && ((n % set) != 0);
  endfunction : exp_len

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench hang guard ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [11:0] row [5];             // [11] slave, [10] counter on, [7:0] setting
    logic [7:0]  ch;                  // random character
    logic        e;                   // expected length flag
    logic [31:0] cw;                  // control word written
    row = '{12'hC02, 12'hC01, 12'h402, 12'h802, 12'hC00};
    pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0; rd = '0; er = 1'b0;
    fails = 0; num_checks = 0; cyc = 0; seed = 32'h0000_21e6;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status_rst", rd, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped_err", {31'h0, er}, 32'h0000_0001);
    // modes: mismatch, exact multiple, master, counter off, setting zero
    for (int i = 0; i < 5; i++) begin
      seed = lfsr_next(seed);
      ch   = seed[7:0];
      e    = exp_len(row[i][11], row[i][10], row[i][7:0], 1);
      cw   = {16'h0000, row[i][7:0], 5'h00, row[i][10], row[i][11], 1'b1};
      apb(1'b1, ssf_pkg::ADDR_CTRL, cw);
      apb(1'b0, ssf_pkg::ADDR_CTRL, 32'h0000_0000);
      chk("ctrl_rb", rd, cw);
      chk("ctrl_err", {31'h0, er}, 32'h0000_0000);
      u_ssf_spi_master.send(1, {8'h00, ch});
      repeat (20) @(posedge pclk);
      apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("len_flag", rd, {20'h0_0000, e, 11'h000});
      apb(1'b0, ssf_pkg::ADDR_DATA, 32'h0000_0000);
      // the holder fills in every mode, so it is emptied in every mode
      chk("rx_word", rd, {24'h00_0000, ch});
      apb(1'b1, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
      apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("zero_keeps", rd, {20'h0_0000, e, 11'h000});
      apb(1'b1, ssf_pkg::ADDR_STATUS, 32'h0000_0800);
      apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("w1c_len", rd, 32'h0000_0000);
    end
    // two characters without a read overflow the one-deep holder
    apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h0000_0003);
    seed = lfsr_next(seed);
    u_ssf_spi_master.send(2, seed[15:0]);
    repeat (20) @(posedge pclk);
    apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("ovf_set", rd, 32'h0000_0004);
    apb(1'b0, ssf_pkg::ADDR_DATA, 32'h0000_0000);
    chk("ovf_word", rd, 32'h0000_0000);
    apb(1'b1, ssf_pkg::ADDR_STATUS, 32'h0000_0004);
    apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("w1c_ovf", rd, 32'h0000_0000);
    // overflow again, then turn the receiver off
    seed = lfsr_next(seed);
    u_ssf_spi_master.send(2, seed[15:0]);
    repeat (20) @(posedge pclk);
    apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h0000_0002);
    apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("rxoff_clr", rd, 32'h0000_0000);
    // emptied holder takes a fresh character without overflow
    apb(1'b1, ssf_pkg::ADDR_CTRL, 32'h0000_0003);
    seed = lfsr_next(seed);
    ch   = seed[7:0];
    u_ssf_spi_master.send(1, {8'h00, ch});
    repeat (20) @(posedge pclk);
    apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("no_ovf", rd, 32'h0000_0000);
    apb(1'b0, ssf_pkg::ADDR_DATA, 32'h0000_0000);
    chk("fresh_word", rd, {24'h00_0000, ch});
    // overflow once more, then a mid-run reset must clear the flags
    seed = lfsr_next(seed);
    u_ssf_spi_master.send(2, seed[15:0]);
    repeat (20) @(posedge pclk);
    apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("ovf_again", rd, 32'h0000_0004);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ssf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status_rst2", rd, 32'h0000_0000);
    test_done();
  end
endmodule : tb
